/* File: src/clock_timebase_pkg.sv */
// Constants shared by the clock, time-base and beep logic.
// Assumes an 8-bit register port and a single oscillator-rate clock.
package clock_timebase_pkg;

   // Register offsets (byte addresses on the register port)
   localparam logic [7:0] CLOCK_CONTROL_STATUS_OFS = 8'h2C;
   localparam logic [7:0] BEEP_CONTROL_OFS = 8'h2D;
   localparam logic [7:0] EVENT_STATUS_OFS = 8'h2E;
   localparam logic [7:0] EVENT_MASK_OFS = 8'h2F;

   // Reset values and the unmapped read value
   localparam logic [7:0] CLOCK_CONTROL_STATUS_RST = 8'h00;
   localparam logic [7:0] BEEP_CONTROL_RST = 8'h00;
   localparam logic [2:0] EVENT_RST = 3'h0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Field positions of the control/status and beep control registers
   localparam int CLK_OUT_EN_BIT = 7;
   localparam int SLOW_DIV_LSB = 5;
   localparam int SLOW_MODE_BIT = 4;
   localparam int TB_SEL_LSB = 2;
   localparam int TB_IRQ_EN_BIT = 1;
   localparam int TB_FLAG_BIT = 0;
   localparam int BEEP_SEL_LSB = 0;

   // Event status bit positions
   localparam int EV_PERIOD_BIT = 0;
   localparam int EV_SLEEP_WAKE_BIT = 1;
   localparam int EV_HALT_WAKE_BIT = 2;

   // Time-base periods in oscillator cycles
   localparam int TB_PERIOD_0 = 16000;
   localparam int TB_PERIOD_1 = 32000;
   localparam int TB_PERIOD_2 = 80000;
   localparam int TB_PERIOD_3 = 200000;

   // Beep tones, specified against an 8 MHz oscillator
   localparam int OSC_REF_HZ = 8000000;
   localparam int BEEP_FREQ_0_HZ = 2000;
   localparam int BEEP_FREQ_1_HZ = 1000;
   localparam int BEEP_FREQ_2_HZ = 500;
   localparam int BEEP_HALF_0 = OSC_REF_HZ / (2 * BEEP_FREQ_0_HZ);
   localparam int BEEP_HALF_1 = OSC_REF_HZ / (2 * BEEP_FREQ_1_HZ);
   localparam int BEEP_HALF_2 = OSC_REF_HZ / (2 * BEEP_FREQ_2_HZ);

   // Power modes of the device as seen by this block
   typedef enum logic [1:0] {
      PM_RUN = 2'b00,
      PM_TIMED_SLEEP = 2'b01,
      PM_FULL_HALT = 2'b10
   } power_mode_t;

endpackage

/* File: src/beep_link_if.sv */
// Signals between the clock controller and its beep generator.
// Both ends run on the same clock; no crossing is involved.
interface beep_link_if;
   logic [1:0] beep_select;
   logic run;
   logic wave;

   modport ctrl (output beep_select, output run, input wave);
   modport gen (input beep_select, input run, output wave);
endinterface

/* File: src/beep_generator.sv */
// Square-wave beep tone generator with three selectable pitches.
// Assumes the selection and run level come from logic on the same clock.
module beep_generator
   import clock_timebase_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int HALF_0 = BEEP_HALF_0,
   parameter int HALF_1 = BEEP_HALF_1,
   parameter int HALF_2 = BEEP_HALF_2
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // Link to the controller
   beep_link_if.gen link
);

   logic [CNT_W-1:0] half_cnt_r;
   logic [CNT_W-1:0] half_lim;
   logic wave_r;

   // Refuse half periods that the counter cannot hold
   if (HALF_0 < 1 || HALF_1 < 1 || HALF_2 < 1 ||
       HALF_0 >= (1 << CNT_W) || HALF_1 >= (1 << CNT_W) || HALF_2 >= (1 << CNT_W)) begin
      $error("beep_generator: half periods must be 1 .. 2**CNT_W-1");
   end

   // Half-period length for the selected tone
   always_comb begin
      case (link.beep_select)
         2'b01: half_lim = CNT_W'(HALF_0 - 1);
         2'b10: half_lim = CNT_W'(HALF_1 - 1);
         default: half_lim = CNT_W'(HALF_2 - 1);
      endcase
   end

   // Toggle every half period gives a 50% duty square wave
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         half_cnt_r <= '0;
         wave_r <= 1'b0;
      end else if (link.beep_select == 2'b00) begin
         half_cnt_r <= '0;
         wave_r <= 1'b0;
      end else if (link.run) begin
         if (half_cnt_r >= half_lim) begin // >= so a pitch change never overruns
            half_cnt_r <= '0;
            wave_r <= ~wave_r;
         end else begin
            half_cnt_r <= half_cnt_r + 1'b1;
         end
      end
   end

   assign link.wave = wave_r;

endmodule

/* File: src/clock_timebase_ctrl.sv */
// Main clock controller: core clock prescaler, clock-out pin, periodic
// time base with wake-up interrupt, beep output and power-mode tracking.
// Assumes CORE_CLK is the oscillator-rate clock and that the core drives the
// register port and mode inputs from logic on that same clock.
//
// Operation
// - Clock-out enable puts core clock on its pin, at half rate in normal mode; otherwise pin left to port.
// - Clock output stays inactive during timed sleep, even when enabled.
// - Slow mode divides oscillator clock by 2, 4, 8 or 16.
// - Divider select only matters in slow mode; else core clock is undivided.
// - Time-base period is 16000, 32000, 80000 or 200000 oscillator cycles.
// - A new time-base choice takes effect only when current period completes.
// - Time-base interrupt enable gates interrupt and wake from timed sleep.
// - Halt with time-base interrupt enabled enters timed sleep, not full halt.
// - Flag sets at end of each period; reading control/status clears it.
// - Beep pin carries 50% square wave: off, ~2 kHz, ~1 kHz, ~500 Hz.
// - Beep keeps running during timed sleep.
// - Reset clears control/status and beep control registers.
// - Time-base interrupt requested only while flag and enable set, under global mask.
// - Full halt freezes counter and registers until a halt-ending wake.
// - Time-base interrupt wakes from timed sleep, never full halt.
module clock_timebase_ctrl
   import clock_timebase_pkg::*;
#(
   parameter int TB_PERIOD_0_P = TB_PERIOD_0,
   parameter int TB_PERIOD_1_P = TB_PERIOD_1,
   parameter int TB_PERIOD_2_P = TB_PERIOD_2,
   parameter int TB_PERIOD_3_P = TB_PERIOD_3,
   parameter int BEEP_HALF_0_P = BEEP_HALF_0,
   parameter int BEEP_HALF_1_P = BEEP_HALF_1,
   parameter int BEEP_HALF_2_P = BEEP_HALF_2
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Core power and interrupt context
   input wire logic HALT_EXEC,
   input wire logic HALT_WAKE,
   input wire logic GLOBAL_IRQ_MASK,
   // Clock outputs
   output logic CORE_TICK,
   output logic CLOCK_OUT_PIN,
   output logic CLOCK_OUT_PIN_OE,
   // Beep pin
   output logic BEEP_PIN,
   output logic BEEP_PIN_OE,
   // Mode and interrupt outputs
   output logic TIMED_SLEEP,
   output logic FULL_HALT,
   output logic TB_IRQ,
   output logic IRQ
);

   localparam int TB_W = 18;

   // Control/status fields
   logic clk_out_en_r;
   logic [1:0] slow_div_r;
   logic slow_mode_r;
   logic [1:0] tb_sel_r;
   logic [1:0] tb_act_r;
   logic irq_en_r;
   logic tb_flag_r;
   logic [1:0] beep_sel_r;
   // Event status and mask
   logic [2:0] ev_status_r;
   logic [2:0] ev_mask_r;
   logic [2:0] ev_set;
   // Time base
   logic [TB_W-1:0] tb_cnt_r;
   logic tb_end;
   // Prescaler
   logic [3:0] div_cnt_r;
   logic [3:0] div_lim;
   logic core_tick_nxt;
   logic clk_pin_nxt;
   // Power mode
   power_mode_t pm_r;
   power_mode_t pm_nxt;
   logic sleep_wake;
   logic halt_wake;
   // Register port decode
   logic wr_ccs;
   logic wr_beep;
   logic wr_ev_status;
   logic wr_ev_mask;
   logic rd_ccs;
   logic regs_live;
   logic [7:0] rdata_nxt;
   // Output flops
   logic [7:0] rdata_r;
   logic core_tick_r;
   logic clk_pin_r;
   logic clk_pin_oe_r;
   logic beep_pin_r;
   logic beep_pin_oe_r;
   logic tb_irq_r;
   logic irq_r;

   beep_link_if beep_link();

   // Refuse periods that the 18-bit counter cannot reach
   if (TB_PERIOD_0_P < 1 || TB_PERIOD_1_P < 1 || TB_PERIOD_2_P < 1 || TB_PERIOD_3_P < 1 ||
       TB_PERIOD_3_P > (1 << TB_W) || TB_PERIOD_2_P > (1 << TB_W) ||
       TB_PERIOD_1_P > (1 << TB_W) || TB_PERIOD_0_P > (1 << TB_W)) begin
      $error("clock_timebase_ctrl: time-base periods must be 1 .. 2**18");
   end

   // Last count of the period chosen by a time-base select code
   function automatic logic [TB_W-1:0] tb_last(input logic [1:0] sel);
      case (sel)
         2'b00: tb_last = TB_W'(TB_PERIOD_0_P - 1);
         2'b01: tb_last = TB_W'(TB_PERIOD_1_P - 1);
         2'b10: tb_last = TB_W'(TB_PERIOD_2_P - 1);
         default: tb_last = TB_W'(TB_PERIOD_3_P - 1);
      endcase
   endfunction

   // Address decode; registers accept writes only while the core runs
   always_comb begin
      regs_live = (pm_r == PM_RUN);
      wr_ccs = 1'b0;
      wr_beep = 1'b0;
      wr_ev_status = 1'b0;
      wr_ev_mask = 1'b0;
      rd_ccs = 1'b0;
      if (ADDR == CLOCK_CONTROL_STATUS_OFS) begin
         wr_ccs = WR && regs_live;
         rd_ccs = RD && regs_live;
      end else if (ADDR == BEEP_CONTROL_OFS) begin
         wr_beep = WR && regs_live;
      end else if (ADDR == EVENT_STATUS_OFS) begin
         wr_ev_status = WR && regs_live;
      end else if (ADDR == EVENT_MASK_OFS) begin
         wr_ev_mask = WR && regs_live;
      end
   end

   // Read mux; unmapped addresses answer zero
   always_comb begin
      rdata_nxt = UNMAPPED_READ;
      if (ADDR == CLOCK_CONTROL_STATUS_OFS) begin
         rdata_nxt[CLK_OUT_EN_BIT] = clk_out_en_r;
         rdata_nxt[SLOW_DIV_LSB +: 2] = slow_div_r;
         rdata_nxt[SLOW_MODE_BIT] = slow_mode_r;
         rdata_nxt[TB_SEL_LSB +: 2] = tb_sel_r;
         rdata_nxt[TB_IRQ_EN_BIT] = irq_en_r;
         rdata_nxt[TB_FLAG_BIT] = tb_flag_r;
      end else if (ADDR == BEEP_CONTROL_OFS) begin
         rdata_nxt[BEEP_SEL_LSB +: 2] = beep_sel_r;
      end else if (ADDR == EVENT_STATUS_OFS) begin
         rdata_nxt[2:0] = ev_status_r;
      end else if (ADDR == EVENT_MASK_OFS) begin
         rdata_nxt[2:0] = ev_mask_r;
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge CORE_CLK) begin
      if (!NRST)
         rdata_r <= 8'h00;
      else if (RD)
         rdata_r <= rdata_nxt;
      else
         rdata_r <= 8'h00;
   end

   // Control fields written by software
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         clk_out_en_r <= CLOCK_CONTROL_STATUS_RST[CLK_OUT_EN_BIT];
         slow_div_r <= CLOCK_CONTROL_STATUS_RST[SLOW_DIV_LSB +: 2];
         slow_mode_r <= CLOCK_CONTROL_STATUS_RST[SLOW_MODE_BIT];
         tb_sel_r <= CLOCK_CONTROL_STATUS_RST[TB_SEL_LSB +: 2];
         irq_en_r <= CLOCK_CONTROL_STATUS_RST[TB_IRQ_EN_BIT];
         beep_sel_r <= BEEP_CONTROL_RST[BEEP_SEL_LSB +: 2];
      end else begin
         if (wr_ccs) begin
            clk_out_en_r <= WDATA[CLK_OUT_EN_BIT];
            slow_div_r <= WDATA[SLOW_DIV_LSB +: 2];
            slow_mode_r <= WDATA[SLOW_MODE_BIT];
            tb_sel_r <= WDATA[TB_SEL_LSB +: 2];
            irq_en_r <= WDATA[TB_IRQ_EN_BIT];
         end
         if (wr_beep)
            beep_sel_r <= WDATA[BEEP_SEL_LSB +: 2]; // Upper bits are not stored
      end
   end

   // Time base: free-running period counter, frozen only in full halt
   assign tb_end = (tb_cnt_r >= tb_last(tb_act_r));
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         tb_cnt_r <= '0;
         tb_act_r <= CLOCK_CONTROL_STATUS_RST[TB_SEL_LSB +: 2];
      end else if (pm_r != PM_FULL_HALT) begin
         if (tb_end) begin
            tb_cnt_r <= '0;
            tb_act_r <= tb_sel_r;
         end else begin
            tb_cnt_r <= tb_cnt_r + 1'b1;
         end
      end
   end

   // Period flag; a period ending in the cycle of a read survives the clear
   always_ff @(posedge CORE_CLK) begin
      if (!NRST)
         tb_flag_r <= CLOCK_CONTROL_STATUS_RST[TB_FLAG_BIT];
      else if (tb_end && pm_r != PM_FULL_HALT)
         tb_flag_r <= 1'b1;
      else if (rd_ccs)
         tb_flag_r <= 1'b0;
   end

   // Wake conditions for the two halt flavours
   assign sleep_wake = (tb_flag_r && irq_en_r) || HALT_WAKE;
   assign halt_wake = HALT_WAKE;

   // Power-mode tracking
   always_comb begin
      pm_nxt = pm_r;
      case (pm_r)
         PM_RUN: begin
            if (HALT_EXEC)
               pm_nxt = irq_en_r ? PM_TIMED_SLEEP : PM_FULL_HALT;
         end
         PM_TIMED_SLEEP: begin
            if (sleep_wake)
               pm_nxt = PM_RUN;
         end
         PM_FULL_HALT: begin
            if (halt_wake)
               pm_nxt = PM_RUN;
         end
         default: pm_nxt = PM_RUN;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST)
         pm_r <= PM_RUN;
      else
         pm_r <= pm_nxt;
   end

   // Event status: set by hardware, cleared by writing one; set wins
   always_comb begin
      ev_set = 3'h0;
      ev_set[EV_PERIOD_BIT] = tb_end && (pm_r != PM_FULL_HALT);
      ev_set[EV_SLEEP_WAKE_BIT] = (pm_r == PM_TIMED_SLEEP) && sleep_wake;
      ev_set[EV_HALT_WAKE_BIT] = (pm_r == PM_FULL_HALT) && halt_wake;
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST)
         ev_status_r <= EVENT_RST;
      else
         ev_status_r <= ev_set | (ev_status_r & ~(wr_ev_status ? WDATA[2:0] : 3'h0));
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST)
         ev_mask_r <= EVENT_RST;
      else if (wr_ev_mask)
         ev_mask_r <= WDATA[2:0];
   end

   // Prescaler: last count of the slow-mode divide ratio
   always_comb begin
      case (slow_div_r)
         2'b00: div_lim = 4'h1;
         2'b01: div_lim = 4'h3;
         2'b10: div_lim = 4'h7;
         default: div_lim = 4'hF;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST)
         div_cnt_r <= 4'h0;
      else if (!slow_mode_r || div_cnt_r >= div_lim) // >= covers a ratio cut mid-count
         div_cnt_r <= 4'h0;
      else
         div_cnt_r <= div_cnt_r + 1'b1;
   end

   // Core tick and pin waveform; the core is stopped in either halt mode
   always_comb begin
      if (pm_r != PM_RUN) begin
         core_tick_nxt = 1'b0;
         clk_pin_nxt = 1'b0;
      end else if (slow_mode_r) begin
         core_tick_nxt = (div_cnt_r >= div_lim);
         clk_pin_nxt = (div_cnt_r <= (div_lim >> 1)) && !(div_cnt_r >= div_lim);
      end else begin
         core_tick_nxt = 1'b1;
         clk_pin_nxt = ~clk_pin_r; // A flop pin can show only half the oscillator rate
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         core_tick_r <= 1'b0;
         clk_pin_r <= 1'b0;
         clk_pin_oe_r <= 1'b0;
      end else begin
         core_tick_r <= core_tick_nxt;
         clk_pin_r <= clk_out_en_r && clk_pin_nxt;
         clk_pin_oe_r <= clk_out_en_r;
      end
   end

   // Beep generator runs except in full halt, including timed sleep
   assign beep_link.beep_select = beep_sel_r;
   assign beep_link.run = (pm_r != PM_FULL_HALT);

   beep_generator #(
      .CNT_W(16),
      .HALF_0(BEEP_HALF_0_P),
      .HALF_1(BEEP_HALF_1_P),
      .HALF_2(BEEP_HALF_2_P)
   ) u_beep (
      .CORE_CLK(CORE_CLK),
      .NRST(NRST),
      .link(beep_link.gen)
   );

   // Beep pin retimed so the port comes straight from a local flop
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         beep_pin_r <= 1'b0;
         beep_pin_oe_r <= 1'b0;
      end else begin
         beep_pin_r <= beep_link.wave;
         beep_pin_oe_r <= (beep_sel_r != 2'b00);
      end
   end

   // Interrupt outputs
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         tb_irq_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         tb_irq_r <= tb_flag_r && irq_en_r && !GLOBAL_IRQ_MASK;
         irq_r <= |(ev_status_r & ev_mask_r);
      end
   end

   // Port drivers
   assign RDATA = rdata_r;
   assign CORE_TICK = core_tick_r;
   assign CLOCK_OUT_PIN = clk_pin_r;
   assign CLOCK_OUT_PIN_OE = clk_pin_oe_r;
   assign BEEP_PIN = beep_pin_r;
   assign BEEP_PIN_OE = beep_pin_oe_r;
   assign TIMED_SLEEP = pm_r[0]; // Code 01 marks timed sleep, so the port is a bare flop
   assign FULL_HALT = pm_r[1]; // Code 10 marks full halt
   assign TB_IRQ = tb_irq_r;
   assign IRQ = irq_r;

endmodule

/* File: tb/clock_timebase_ctrl_properties.sv */
// Port-level assertions for the clock, time-base and beep controller.
// Assumes one clock domain and the synchronous active-low reset NRST.
module clock_timebase_ctrl_properties (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // Register port and core context
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic HALT_EXEC,
   input wire logic HALT_WAKE,
   input wire logic GLOBAL_IRQ_MASK,
   // Observed outputs
   input wire logic CORE_TICK,
   input wire logic CLOCK_OUT_PIN,
   input wire logic BEEP_PIN,
   input wire logic BEEP_PIN_OE,
   input wire logic TIMED_SLEEP,
   input wire logic FULL_HALT,
   input wire logic TB_IRQ
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   // Read data may only show in the cycle right after a read strobe
   a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data seen without a read");
   // Global mask must gate the request, one cycle late
   a_tbirq_gmask: assert property (TB_IRQ |-> $past(!GLOBAL_IRQ_MASK))
      else $error("time-base request while globally masked");
   // Beep off means a quiet pin
   a_beep_off: assert property (!BEEP_PIN_OE && $past(!BEEP_PIN_OE) |-> !BEEP_PIN)
      else $error("beep pin active while beep is off");
   // Clock-out is held inactive once sleep has settled
   a_clkout_sleep: assert property (TIMED_SLEEP ##1 TIMED_SLEEP |-> !CLOCK_OUT_PIN)
      else $error("clock out active in timed sleep");
   // Core clock stops in both low-power modes
   a_tick_halted: assert property ((TIMED_SLEEP || FULL_HALT) ##1 (TIMED_SLEEP || FULL_HALT) |-> !CORE_TICK)
      else $error("core tick running in low-power mode");
   // Halt in run enters exactly one low-power mode next cycle
   a_halt_entry: assert property (HALT_EXEC && !TIMED_SLEEP && !FULL_HALT |=> TIMED_SLEEP != FULL_HALT)
      else $error("halt did not enter a single low-power mode");
   // Only a halt-ending wake leaves full halt
   a_halt_holds: assert property (FULL_HALT && !HALT_WAKE |=> FULL_HALT)
      else $error("full halt left without a wake");
   // A halt-ending wake leaves either mode in one edge
   a_wake_exit: assert property ((TIMED_SLEEP || FULL_HALT) && HALT_WAKE |=> !TIMED_SLEEP && !FULL_HALT)
      else $error("wake did not end low-power mode");
endmodule

bind clock_timebase_ctrl clock_timebase_ctrl_properties clock_timebase_ctrl_properties_inst (
   .CORE_CLK(CORE_CLK), .NRST(NRST), .RD(RD), .RDATA(RDATA), .HALT_EXEC(HALT_EXEC),
   .HALT_WAKE(HALT_WAKE), .GLOBAL_IRQ_MASK(GLOBAL_IRQ_MASK), .CORE_TICK(CORE_TICK),
   .CLOCK_OUT_PIN(CLOCK_OUT_PIN), .BEEP_PIN(BEEP_PIN), .BEEP_PIN_OE(BEEP_PIN_OE),
   .TIMED_SLEEP(TIMED_SLEEP), .FULL_HALT(FULL_HALT), .TB_IRQ(TB_IRQ)
);

/* File: tb/tb_top.sv */
// Self-checking bench for the clock, time-base and beep controller.
// Assumes shortened periods (16/32/80/200) and a first beep half period of 4;
// the two lower tones keep their real half periods.
module tb_top import clock_timebase_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PER[4] = '{16, 32, 80, 200};
   logic clk, nrst, wr, rd, rd_d, halt_exec, halt_wake, gmask;
   logic [7:0] addr, wdata, rdata, r;
   logic core_tick, co_pin, co_oe, beep_pin, beep_oe, sleep, halt, tb_irq, irq;
   logic [15:0] q[$];
   logic [15:0] ent;
   int fails = 0, checked = 0, cyc = 0, t0, tk, co, bp, bh, old, h;

   clock_timebase_ctrl #(.TB_PERIOD_0_P(16), .TB_PERIOD_1_P(32), .TB_PERIOD_2_P(80), .TB_PERIOD_3_P(200),
      .BEEP_HALF_0_P(4)) clock_timebase_ctrl_inst (
      .CORE_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .HALT_EXEC(halt_exec), .HALT_WAKE(halt_wake), .GLOBAL_IRQ_MASK(gmask), .CORE_TICK(core_tick),
      .CLOCK_OUT_PIN(co_pin), .CLOCK_OUT_PIN_OE(co_oe), .BEEP_PIN(beep_pin), .BEEP_PIN_OE(beep_oe),
      .TIMED_SLEEP(sleep), .FULL_HALT(halt), .TB_IRQ(tb_irq), .IRQ(irq));

   // Clock and cycle count
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Counts that may exceed a byte
   task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Read results: the oldest expectation is taken when the data cycle comes
   always @(posedge clk) begin
      rd_d <= rd;
      if (rd_d === 1'b1) begin
         ent = q.pop_front();
         chk(rdata & ent[15:8], ent[7:0] & ent[15:8], "read data");
      end
   end

   // Idle cycle after each strobe keeps one assignment per signal per step
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      addr <= a;
      rd <= 1'b1;
      q.push_back({m, e});
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask

   // Flag must read set once, then clear
   task automatic clr();
      rd_reg(8'h2C, 8'h01, 8'h01);
      rd_reg(8'h2C, 8'h00, 8'h01);
   endtask

   task automatic wait_sig(ref logic s, input logic v);
      int k;
      k = 0;
      while (s !== v && k < 500) begin
         @(posedge clk);
         k++;
      end
      chk(8'(k < 500), 8'h01, "wait bound");
   endtask

   // Edges are counted against the previous sample, kept by hand
   task automatic count(input int n);
      logic pc, pb;
      tk = 0;
      co = 0;
      bp = 0;
      bh = 0;
      pc = co_pin;
      pb = beep_pin;
      repeat (n) begin
         @(posedge clk);
         tk += int'(core_tick === 1'b1);
         co += int'(co_pin === 1'b1 && pc === 1'b0);
         bp += int'(beep_pin === 1'b1 && pb === 1'b0);
         bh += int'(beep_pin === 1'b1);
         pc = co_pin;
         pb = beep_pin;
      end
   endtask

   // Watchdog against a hang; the real-length beep tones make tests take about 62000 cycles
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      end_sim();
   end

   initial begin
      {nrst, wr, rd, halt_exec, halt_wake, gmask, addr, wdata} = '0;
      void'($urandom(54));
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_reg(8'h2C, 8'h00, 8'hFE);
      rd_reg(8'h2D, 8'h00, 8'hFF);
      rd_reg(8'h30, 8'h00, 8'hFF);
      r = 8'($urandom);
      wr_reg(8'h2D, r & 8'h03);
      rd_reg(8'h2D, r & 8'h03, 8'hFF);
      wr_reg(8'h2C, r & 8'hF2);
      rd_reg(8'h2C, r & 8'hF2, 8'hFE);
      // Divider ratios with clock-out on; last pass is normal mode
      for (int s = 0; s < 5; s++) begin
         wr_reg(8'h2C, s == 4 ? 8'h80 : {1'b1, 2'(s), 5'h10});
         repeat (4) @(posedge clk);
         count(64);
         chk(8'(tk), s == 4 ? 8'd64 : 8'(64 >> (s + 1)), "core tick count");
         chk(8'(co), s == 4 ? 8'd32 : 8'(64 >> (s + 1)), "clock out rises");
         chk({7'h0, co_oe}, 8'h01, "clock out drive");
      end
      wr_reg(8'h2C, 8'h00);
      @(posedge clk);
      chk({7'h0, co_oe}, 8'h00, "clock out released");
      // Each beep pitch over two whole periods, after the first toggle has settled
      for (int b = 0; b < 4; b++) begin
         h = b < 2 ? 4 : (b == 2 ? BEEP_HALF_1 : BEEP_HALF_2);
         wr_reg(8'h2D, {6'h0, 2'(b)});
         repeat (h + 4) @(posedge clk);
         count(4 * h);
         chk(8'(bp), b == 0 ? 8'd0 : 8'd2, "beep rises");
         chk_cnt(bh, b == 0 ? 0 : 2 * h, "beep high time");
         chk({7'h0, beep_oe}, 8'(b != 0), "beep drive");
      end
      // Period lengths; each change lands only after the running period
      wr_reg(8'h2C, 8'h02);
      wait_sig(tb_irq, 1'b1);
      clr();
      wait_sig(tb_irq, 1'b1);
      t0 = cyc;
      clr();
      old = 0;
      for (int s = 1; s < 4; s++) begin
         wr_reg(8'h2C, {4'h0, 2'(s), 2'b10});
         wait_sig(tb_irq, 1'b1);
         chk(8'(cyc - t0), 8'(PER[old]), "old period kept");
         t0 = cyc;
         clr();
         wait_sig(tb_irq, 1'b1);
         chk(8'(cyc - t0), 8'(PER[s]), "period length");
         t0 = cyc;
         clr();
         old = s;
      end
      // Event status, mask and the global mask
      wait_sig(tb_irq, 1'b1);
      chk({7'h0, irq}, 8'h00, "masked event");
      wr_reg(8'h2F, 8'h01);
      @(posedge clk);
      chk({7'h0, irq}, 8'h01, "unmasked event");
      gmask <= 1'b1;
      repeat (3) @(posedge clk);
      chk({7'h0, tb_irq}, 8'h00, "global mask");
      gmask <= 1'b0;
      repeat (3) @(posedge clk);
      chk({7'h0, tb_irq}, 8'h01, "global unmask");
      wr_reg(8'h2E, 8'h01);
      @(posedge clk);
      chk({7'h0, irq}, 8'h00, "event cleared");
      rd_reg(8'h2E, 8'h00, 8'h01);
      clr();
      // Timed sleep: clock out stops, beep runs, time base wakes
      wr_reg(8'h2D, 8'h01);
      wr_reg(8'h2C, 8'h8E);
      halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      repeat (3) @(posedge clk);
      chk({6'h0, sleep, halt}, 8'h02, "timed sleep entered");
      count(32);
      chk(8'(tk + co), 8'h00, "clocks stopped");
      chk(8'(bp), 8'd4, "beep in sleep");
      wait_sig(sleep, 1'b0);
      rd_reg(8'h2E, 8'h02, 8'h02);
      clr();
      // Full halt ignores the time base until a wake
      wr_reg(8'h2C, 8'h8C);
      halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      repeat (450) @(posedge clk);
      chk({6'h0, sleep, halt}, 8'h01, "full halt held");
      chk({7'h0, tb_irq}, 8'h00, "no request in halt");
      halt_wake <= 1'b1;
      @(posedge clk);
      halt_wake <= 1'b0;
      repeat (2) @(posedge clk);
      chk({7'h0, halt}, 8'h00, "halt ended");
      rd_reg(8'h2E, 8'h04, 8'h04);
      // Reset in mid-run clears both registers
      wr_reg(8'h2D, 8'h03);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_reg(8'h2C, 8'h00, 8'hFF);
      rd_reg(8'h2D, 8'h00, 8'hFF);
      end_sim();
   end
endmodule
